/* design/srom_array.sv */
// module: read-only byte array, registered read, contents from a fixed function
`timescale 1ns/1ps
module srom_array (
  input  wire logic                                 clk,
  input  wire logic                                 nrst,
  input  wire logic [srom_pkg::array_addr_width-1:0] addr,
  output logic      [srom_pkg::data_width-1:0]       data
);

  // ****************************************
  // contents: a fixed pattern derived from the address
  // ****************************************
  function automatic logic [srom_pkg::data_width-1:0] rom_word(
    input logic [srom_pkg::array_addr_width-1:0] a);
    rom_word = a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
  endfunction

  logic [srom_pkg::data_width-1:0] next_data;

  always_comb begin
    next_data = rom_word(addr);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data <= srom_pkg::data_reset;
    end else begin
      data <= next_data;
    end
  end

endmodule

/* design/srom_pkg.sv */
// package: constants and carrier types for the serial read-only memory slave
package srom_pkg;

  // ****************************************
  // instruction codes and frame layout
  // ****************************************
  localparam logic [7:0] code_normal_fetch = 8'h03;
  localparam logic [7:0] code_quick_fetch  = 8'h0b;
  localparam int         byte_bits         = 8;
  localparam int         addr_bytes        = 3;
  localparam int         dummy_bytes       = 1;
  localparam int         addr_width        = 24;
  localparam int         array_addr_width  = 22;
  localparam int         data_width        = 8;
  localparam logic [2:0] bit_cnt_reset     = 3'h0;
  localparam logic [1:0] byte_cnt_reset    = 2'h0;
  localparam logic [addr_width-1:0] addr_reset = 24'h000000;
  localparam logic [data_width-1:0] data_reset = 8'h00;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic select_n;
    logic pause_n;
  } pins_t;

  typedef enum logic [5:0] {
    st_idle   = 6'b000001,
    st_instr  = 6'b000010,
    st_addr   = 6'b000100,
    st_dummy  = 6'b001000,
    st_data   = 6'b010000,
    st_ignore = 6'b100000
  } state_t;

endpackage

/* design/srom_spi_slave.sv */
// module: spi slave front end of the serial read-only memory
`timescale 1ns/1ps
// Function
// [RULE1] output bit changes after a falling serial clock edge
// [RULE2] input bits captured on rising serial clock edges
// [RULE3] select high deselects and ignores bus; low activates
// [RULE4] no instruction before a select falling edge after reset
// [RULE5] master uses mode 0 or mode 3
// [RULE6] stay active until internal cycle ends after deselect
// [RULE7] pause only entered while selected
// [RULE8] pause starts at once if clock low, else next clock low
// [RULE9] pause ends at once if clock low, else next clock low
// [RULE10] during pause output high impedance, inputs ignored
// [RULE11] pause freezes counters; shifting resumes where it stopped
// [RULE12] deselect during pause resets interface logic
// [RULE13] master raises pause before reselecting after deselect in pause
// [RULE14] master should keep select low through whole pause
// [RULE15] all fields msb first
// [RULE16] first bit captured on first rising edge after select falls
// [RULE17] each transaction starts with one instruction byte
// [RULE18] 03h normal fetch, 0bh quick fetch with one dummy byte
// [RULE19] data streams while master keeps clocking
// [RULE20] deselect mid byte stops fetch cleanly
// [RULE21] top two address bits ignored
// [RULE22] array is four mebibytes of bytes
// [RULE23] address advances per byte and wraps to zero
// [RULE24] held in reset while power-on reset asserted
// [RULE25] unknown instruction ignored until deselect
// [RULE26] output high impedance while deselected
module srom_spi_slave (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic select_n,
  input  wire logic pause_n,
  output logic      miso,
  output logic      miso_oe_n,
  output logic      active
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  srom_pkg::pins_t pins_meta;
  srom_pkg::pins_t pins_sync;
  srom_pkg::pins_t pins_prev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin // RULE24
      // select resets low: a pin held low since power-up then shows no false fall
      pins_meta <= '{sclk: 1'b0, mosi: 1'b0, select_n: 1'b0, pause_n: 1'b1};
      pins_sync <= '{sclk: 1'b0, mosi: 1'b0, select_n: 1'b0, pause_n: 1'b1};
      pins_prev <= '{sclk: 1'b0, mosi: 1'b0, select_n: 1'b0, pause_n: 1'b1};
    end else begin
      pins_meta <= '{sclk: sclk, mosi: mosi, select_n: select_n, pause_n: pause_n};
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_high;

  assign sclk_rise = pins_sync.sclk && !pins_prev.sclk;
  assign sclk_fall = !pins_sync.sclk && pins_prev.sclk;
  assign sel_fall  = !pins_sync.select_n && pins_prev.select_n;
  assign sel_high  = pins_sync.select_n;

  // ****************************************
  // pause tracking
  // ****************************************
  logic paused;
  logic next_paused;

  always_comb begin
    next_paused = paused;
    if (sel_high) begin
      next_paused = 1'b0; // RULE12
    end else if (!pins_sync.sclk) begin
      next_paused = !pins_sync.pause_n; // RULE7 RULE8 RULE9
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      paused <= 1'b0;
    end else begin
      paused <= next_paused;
    end
  end

  // ****************************************
  // protocol engine
  // ****************************************
  srom_pkg::state_t                       state;
  srom_pkg::state_t                       next_state;
  logic [2:0]                             bit_cnt;
  logic [2:0]                             next_bit_cnt;
  logic [1:0]                             byte_cnt;
  logic [1:0]                             next_byte_cnt;
  logic [7:0]                             shift_in;
  logic [7:0]                             next_shift_in;
  logic                                   quick;
  logic                                   next_quick;
  logic [srom_pkg::addr_width-1:0]        addr;
  logic [srom_pkg::addr_width-1:0]        next_addr;
  logic [7:0]                             shift_out;
  logic [7:0]                             next_shift_out;
  logic                                   next_miso;
  logic                                   next_oe_n;
  logic                                   armed;
  logic                                   next_armed;
  logic [srom_pkg::data_width-1:0]        rom_data;
  logic [7:0]                             in_byte;
  logic                                   byte_done;

  assign in_byte   = {shift_in[6:0], pins_sync.mosi}; // RULE15
  assign byte_done = (bit_cnt == 3'(srom_pkg::byte_bits - 1));

  srom_array u_array (
    .clk  (clk),
    .nrst (nrst),
    .addr (addr[srom_pkg::array_addr_width-1:0]), // RULE21 RULE22
    .data (rom_data)
  );

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_shift_in  = shift_in;
    next_quick     = quick;
    next_addr      = addr;
    next_shift_out = shift_out;
    next_miso      = miso;
    next_armed     = armed;
    next_oe_n      = 1'b1;
    if (sel_high || (paused && sel_high)) begin // RULE3 RULE12 RULE20
      next_state    = srom_pkg::st_idle;
      next_bit_cnt  = srom_pkg::bit_cnt_reset;
      next_byte_cnt = srom_pkg::byte_cnt_reset;
    end else if (sel_fall) begin // RULE4 RULE16 RULE17
      next_armed    = 1'b1;
      next_state    = srom_pkg::st_instr;
      next_bit_cnt  = srom_pkg::bit_cnt_reset;
      next_byte_cnt = srom_pkg::byte_cnt_reset;
    end else if (!paused && armed) begin // RULE10 RULE11
      next_oe_n = !(state == srom_pkg::st_data); // RULE25 RULE26
      unique case (state)
        srom_pkg::st_idle, srom_pkg::st_ignore: begin
          next_oe_n = 1'b1;
        end
        srom_pkg::st_instr: begin
          if (sclk_rise) begin // RULE2
            next_shift_in = in_byte;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (byte_done) begin
              next_quick = (in_byte == srom_pkg::code_quick_fetch);
              if (in_byte == srom_pkg::code_normal_fetch
                  || in_byte == srom_pkg::code_quick_fetch) begin // RULE18
                next_state = srom_pkg::st_addr;
              end else begin
                next_state = srom_pkg::st_ignore; // RULE25
              end
            end
          end
        end
        srom_pkg::st_addr: begin
          if (sclk_rise) begin
            next_addr    = {addr[srom_pkg::addr_width-2:0], pins_sync.mosi}; // RULE15
            next_bit_cnt = bit_cnt + 3'h1;
            if (byte_done) begin
              next_byte_cnt = byte_cnt + 2'h1;
              if (byte_cnt == 2'(srom_pkg::addr_bytes - 1)) begin
                next_byte_cnt = srom_pkg::byte_cnt_reset;
                next_state    = quick ? srom_pkg::st_dummy : srom_pkg::st_data; // RULE18
              end
            end
          end
        end
        srom_pkg::st_dummy: begin
          if (sclk_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (byte_done) begin
              next_state = srom_pkg::st_data;
            end
          end
        end
        srom_pkg::st_data: begin
          if (sclk_fall) begin // RULE1 RULE19
            if (bit_cnt == srom_pkg::bit_cnt_reset) begin
              next_miso      = rom_data[7];
              next_shift_out = {rom_data[6:0], 1'b0};
              next_addr      = addr + 24'h000001; // RULE23
            end else begin
              next_miso      = shift_out[7];
              next_shift_out = {shift_out[6:0], 1'b0};
            end
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        default: begin
          next_state = srom_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin // RULE24
      state     <= srom_pkg::st_idle;
      bit_cnt   <= srom_pkg::bit_cnt_reset;
      byte_cnt  <= srom_pkg::byte_cnt_reset;
      shift_in  <= 8'h00;
      quick     <= 1'b0;
      addr      <= srom_pkg::addr_reset;
      shift_out <= 8'h00;
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
      armed     <= 1'b0;
      active    <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      shift_in  <= next_shift_in;
      quick     <= next_quick;
      addr      <= next_addr;
      shift_out <= next_shift_out;
      miso      <= next_miso;
      miso_oe_n <= next_oe_n;
      armed     <= next_armed;
      active    <= (!sel_high && armed) || (state != srom_pkg::st_idle); // RULE6
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_oe_deselect: assert property (@(posedge clk) disable iff (!nrst) // RULE26
    pins_sync.select_n |=> miso_oe_n)
    else $error("output driven while deselected");

  a_oe_pause: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    paused |=> miso_oe_n)
    else $error("output driven during pause");

  a_pause_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    paused && !sel_high |=> $stable(bit_cnt) && $stable(addr))
    else $error("state moved during pause");

  a_pause_sel: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    sel_high |=> !paused)
    else $error("pause while deselected");

  a_pause_clk_low: assert property (@(posedge clk) disable iff (!nrst) // RULE8
    $rose(paused) |-> !$past(pins_sync.sclk))
    else $error("pause entered with clock high");

  a_pause_end: assert property (@(posedge clk) disable iff (!nrst) // RULE9
    $fell(paused) && !$past(sel_high) |-> !$past(pins_sync.sclk))
    else $error("pause left with clock high");

  a_miso_on_fall: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    !sclk_fall && !sel_fall |=> $stable(miso))
    else $error("output bit changed off a falling edge");

  a_unknown_quiet: assert property (@(posedge clk) disable iff (!nrst) // RULE25
    state == srom_pkg::st_ignore && !sel_high |=> miso_oe_n
      && state == srom_pkg::st_ignore)
    else $error("unknown instruction not ignored");

  a_deselect_idle: assert property (@(posedge clk) disable iff (!nrst) // RULE12
    sel_high |=> state == srom_pkg::st_idle)
    else $error("deselect did not reset interface");

  a_deselect_standby: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    sel_high ##1 sel_high |=> !active)
    else $error("still active after deselect");

  a_arm_on_fall: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    $rose(armed) |-> $past(sel_fall))
    else $error("engine armed without a select fall");

  a_instr_start: assert property (@(posedge clk) disable iff (!nrst) // RULE16
    sel_fall |=> state == srom_pkg::st_instr && bit_cnt == srom_pkg::bit_cnt_reset)
    else $error("select fall did not start an instruction");

  a_capture_rise: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    !sclk_rise |=> $stable(shift_in))
    else $error("input shifted off a rising edge");

  a_data_drive: assert property (@(posedge clk) disable iff (!nrst) // RULE19
    state == srom_pkg::st_data && armed && !paused && !sel_high
      && !sel_fall |=> !miso_oe_n)
    else $error("output not driven in data phase");

  a_addr_step: assert property (@(posedge clk) disable iff (!nrst) // RULE23
    state == srom_pkg::st_data && sclk_fall && bit_cnt == srom_pkg::bit_cnt_reset && armed
      && !paused && !sel_high && !sel_fall |=> addr == $past(addr) + 24'h000001)
    else $error("address did not advance on a new byte");

endmodule

/* test/serial_rom_spi_read_slave_tb.sv */
// testbench: random and corner fetches through the spi master model
`timescale 1ns/1ps
module serial_rom_spi_read_slave_tb;
  logic clk;
  logic nrst;
  logic sclk;
  logic mosi;
  logic select_n;
  logic pause_n;
  logic miso;
  logic miso_oe_n;
  logic active;
  int   n_mismatch;
  int   compares;
  logic [7:0] rx;
  logic       hz;

  srom_spi_slave dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .mosi(mosi),
    .select_n(select_n), .pause_n(pause_n), .miso(miso), .miso_oe_n(miso_oe_n),
    .active(active));
  spi_master_model mst_u (.clk(clk), .miso(miso), .miso_oe_n(miso_oe_n), .sclk(sclk),
    .mosi(mosi), .select_n(select_n), .pause_n(pause_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] rom_byte(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // one fetch: pb pauses data byte 0, cut > 0 ends on a partial byte
  // ****************************************
  task automatic fetch(input logic [7:0] code, input logic [23:0] a, input int n,
                       input logic mode3, input int pb, input int cut);
    logic       known;
    logic [7:0] d;
    logic       z;
    known = (code == 8'h03) || (code == 8'h0b);
    mst_u.open_frame(mode3);
    mst_u.xfer(code, -1, 0, d, z);
    for (int k = 2; k >= 0; k--) mst_u.xfer(a[k*8 +: 8], -1, 0, d, z);
    if (code == 8'h0b) mst_u.xfer(8'($urandom), -1, 0, d, z);
    for (int k = 0; k < n; k++) begin
      mst_u.xfer(8'($urandom), (k == 0) ? pb : -1, 0, d, z);
      check("oe_n_data", {7'h0, miso_oe_n}, {7'h0, ~known});
      if (known) check("data", d, rom_byte(a[21:0] + 22'(k)));
      if (k == 0 && pb >= 0) check("pause_z", {7'h0, z}, 8'h01);
    end
    if (cut > 0) mst_u.xfer(8'h00, -1, cut, d, z);
    mst_u.close_frame();
    check("oe_n_idle", {7'h0, miso_oe_n}, 8'h01);
    check("active_idle", {7'h0, active}, 8'h00);
  endtask

  initial begin
    nrst       = 1'b0;
    n_mismatch = 0;
    compares   = 0;
    void'($urandom(84));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    mst_u.wait_clk(4);
    // select low since power-up: the frame must be ignored
    mst_u.xfer(8'h03, -1, 0, rx, hz);
    for (int k = 0; k < 4; k++) mst_u.xfer(8'h00, -1, 0, rx, hz);
    check("no_select_edge", {7'h0, miso_oe_n}, 8'h01);
    mst_u.close_frame();
    fetch(8'h03, 24'hc00010, 2, 1'b0, -1, 0);
    fetch(8'h0b, 24'h3ffffe, 4, 1'b1, -1, 0);
    fetch(8'h03, 24'h123456, 2, 1'b0, 4, 0);
    fetch(8'h0b, 24'h0a0b0c, 1, 1'b1, 0, 3);
    fetch(8'h9f, 24'h000001, 2, 1'b0, -1, 0);
    mst_u.open_frame(1'b0);
    mst_u.xfer(8'h03, -1, 0, rx, hz);
    mst_u.drop_in_pause();
    check("oe_n_drop", {7'h0, miso_oe_n}, 8'h01);
    fetch(8'h03, 24'h00ff00, 1, 1'b0, -1, 0);
    mst_u.open_frame(1'b0);
    mst_u.xfer(8'h0b, -1, 0, rx, hz);
    nrst <= 1'b0;
    mst_u.wait_clk(2);
    check("oe_n_reset", {7'h0, miso_oe_n}, 8'h01);
    check("active_reset", {7'h0, active}, 8'h00);
    nrst <= 1'b1;
    mst_u.close_frame();
    repeat (8) begin
      fetch(($urandom % 3 == 0) ? 8'($urandom) : (($urandom % 2) ? 8'h0b : 8'h03),
            24'($urandom), 1 + $urandom % 3, 1'($urandom), -1, 0);
    end
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule

/* test/spi_master_model.sv */
// spi bus master model driving the serial memory pins
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      sclk,
  output logic      mosi,
  output logic      select_n,
  output logic      pause_n
);
  logic idle_high;
  // select starts low so the power-up edge rule is exercised
  initial begin
    sclk      = 1'b0;
    mosi      = 1'b0;
    select_n  = 1'b0;
    pause_n   = 1'b1;
    idle_high = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic open_frame(input logic mode3);
    idle_high = mode3;
    sclk <= mode3;
    wait_clk(4);
    select_n <= 1'b0;
    wait_clk(4);
  endtask
  // launch on fall, device captures on rise; last_bit > 0 cuts the byte short
  task automatic xfer(input logic [7:0] tx, input int pb, input int last_bit,
                      output logic [7:0] rx, output logic held_z);
    held_z = 1'b1;
    rx = 8'h00;
    for (int i = 7; i >= last_bit; i--) begin
      sclk <= 1'b0;
      mosi <= tx[i];
      wait_clk(4);
      if (i == pb) begin
        pause_n <= 1'b0;
        wait_clk(6);
        repeat (2) begin
          sclk <= 1'b1;
          mosi <= ~tx[i];
          wait_clk(4);
          held_z &= miso_oe_n;
          sclk <= 1'b0;
          mosi <= tx[i];
          wait_clk(4);
        end
        pause_n <= 1'b1;
        wait_clk(6);
      end
      sclk <= 1'b1;
      wait_clk(2);
      rx[i] = miso_oe_n ? ~miso : miso; // a released line reads back inverted
      wait_clk(2);
    end
  endtask
  task automatic close_frame();
    sclk <= idle_high;
    wait_clk(4);
    select_n <= 1'b1;
    mosi <= ~mosi;
    wait_clk(8);
  endtask
  task automatic drop_in_pause();
    sclk <= 1'b0;
    wait_clk(4);
    pause_n <= 1'b0;
    wait_clk(6);
    select_n <= 1'b1;
    wait_clk(6);
    pause_n <= 1'b1;
    wait_clk(6);
  endtask
endmodule
